/* design/modem_cfg_pkg.sv */
// Purpose: Shared constants and field layouts of the modem configuration block
// Assumes: APB word registers, 8-bit fields in the low bits
// Notes: Both configuration registers are write-only
package modem_cfg_pkg;
    // Byte addresses on APB
    localparam logic [7:0] ADDR_RATE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OP_MODE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int REG_W = 8;

    // Symbol-rate and receive tuning fields, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] symbol_clock_divider_sel;
        logic [1:0] sync_mismatch_tolerance;
        logic [1:0] level_measure_mode;
        logic [1:0] clock_loop_bandwidth;
    } rate_ctrl_t;

    // Operating mode fields, bit 7 down to bit 0
    typedef struct packed {
        logic interrupt_pin_enable;
        logic symbol_polarity_invert;
        logic direction_select;
        logic receive_eye_test;
        logic low_power_select;
        logic [2:0] spare;
    } op_mode_t;

    localparam rate_ctrl_t RATE_CTRL_RESET = 8'h00;
    localparam op_mode_t OP_MODE_RESET = 8'h00;

    // Level measurement modes
    localparam logic [1:0] LVL_HOLD = 2'h0;
    localparam logic [1:0] LVL_TRACK = 2'h1;
    localparam logic [1:0] LVL_LOSSY = 2'h2;
    localparam logic [1:0] LVL_SLOW = 2'h3;

    // Clock recovery loop bandwidths
    localparam logic [1:0] BW_HOLD = 2'h0;
    localparam logic [1:0] BW_NARROW = 2'h1;
    localparam logic [1:0] BW_MEDIUM = 2'h2;
    localparam logic [1:0] BW_WIDE = 2'h3;

    // Divider: base ratio 512, doubled per code step
    localparam int DIV_W = 13;
    localparam logic [DIV_W-1:0] DIV_BASE = 13'h0200;
    localparam logic [DIV_W-1:0] STEP_NARROW = 13'h0001;
    localparam logic [DIV_W-1:0] STEP_MEDIUM = 13'h0004;
    localparam logic [DIV_W-1:0] STEP_WIDE = 13'h0010;

    // Allowed mismatch totals per tolerance code
    localparam logic [3:0] TOL_CODE0 = 4'h0;
    localparam logic [3:0] TOL_CODE1 = 4'h2;
    localparam logic [3:0] TOL_CODE2 = 4'h4;
    localparam logic [3:0] TOL_CODE3 = 4'h6;
    localparam int MISMATCH_W = 6;

    // Settling after leaving powersave, in symbol times
    localparam int SETTLE_SYMBOLS = 20;

    // Status word bit positions
    localparam int ST_DIR = 0;
    localparam int ST_LOWPWR = 1;
    localparam int ST_VALID = 2;
    localparam int ST_LVL_ACQ = 3;
    localparam int ST_SYNC = 4;

    typedef enum logic {ACQ_IDLE, ACQ_SLOW_PEAK} acq_state_t;
endpackage : modem_cfg_pkg

/* design/modem_mode_regs.sv */
// Purpose: APB-reached mode and tuning registers of a 4-level FSK modem
// Assumes: pclk is the crystal clock; status flag and datapath are outside
// Notes: Configuration registers read back as zero; status word is readable
`timescale 1ns/1ns
`default_nettype none
module modem_mode_regs #(
    parameter int SETTLE_COUNT = modem_cfg_pkg::SETTLE_SYMBOLS
) (
    input wire logic pclk, // Crystal rate clock
    input wire logic presetn, // Async reset, active low
    input wire logic [7:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic status_irq_flag, // Interrupt flag of the status logic
    input wire logic [1:0] tx_symbol_in, // Symbol level code to send
    input wire logic [1:0] rx_baseband_in, // Sliced receive level code
    input wire logic rx_symbol_valid, // Receive symbol strobe
    input wire logic [1:0] sync_expected, // Expected sync symbol code
    input wire logic sync_search_start, // Start of a sync comparison
    input wire logic sync_search_end, // Last symbol of a comparison
    input wire logic level_acquire_sequence, // Start level acquisition
    input wire logic symbol_clock_acquire_sequence, // Clock acquisition active
    input wire logic phase_early, // Recovered clock early
    input wire logic phase_late, // Recovered clock late
    output logic symbol_tick, // Nominal symbol strobe
    output logic [1:0] tx_baseband_out, // Polarity-corrected tx code
    output logic [1:0] rx_symbol_level, // Polarity-corrected rx code
    output logic sync_found, // Sync pattern accepted, pulse
    output logic [1:0] level_mode_out, // Effective level mode
    output logic offset_cap_connect, // Offset capacitors in circuit
    output logic peak_fast_discharge, // Short discharge time constant
    output logic [1:0] loop_bw_out, // Effective loop bandwidth
    output logic interrupt_out_n, // Interrupt pin, active low
    output logic task_cancel, // Cancel current task, pulse
    output logic buffer_free_set, // Set buffer-free, no interrupt
    output logic eye_route, // Equalised rx to tx buffer
    output logic analog_enable, // Filters and recovery powered
    output logic tx_weak_bias, // Tx pin weakly tied to bias
    output logic output_valid // Filters settled
);
    if (SETTLE_COUNT < 1 || SETTLE_COUNT > 255) begin : g_chk
        $error("modem_mode_regs: SETTLE_COUNT out of range");
    end

    typedef struct packed {
        modem_cfg_pkg::rate_ctrl_t ctrl_wr; // Written, waits for symbol
        modem_cfg_pkg::op_mode_t mode_wr;
        modem_cfg_pkg::rate_ctrl_t ctrl;    // In use
        modem_cfg_pkg::op_mode_t mode;
        modem_cfg_pkg::acq_state_t acq;
        logic [modem_cfg_pkg::MISMATCH_W-1:0] mismatch;
        logic [7:0] settle;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] tx_out;
        logic [1:0] rx_level;
        logic sync_found;
        logic [1:0] level_mode;
        logic cap_connect;
        logic fast_discharge;
        logic [1:0] loop_bw;
        logic irq_n;
        logic task_cancel;
        logic buffer_free_flag_set;
        logic eye_route;
        logic analog_en;
        logic weak_bias;
        logic out_valid;
    } regs_state_t;

    regs_state_t r_reg, r_next;
    logic tick;
    logic fb_en;
    logic [modem_cfg_pkg::DIV_W-1:0] step;

    ////////////////////////////////////////////////////////////////////////
    // Level distance between two level codes
    function automatic logic [1:0] level_distance(input logic [1:0] a, input logic [1:0] b);
        level_distance = (a > b) ? a - b : b - a;
    endfunction : level_distance

    // Reverse a level code about the bias point
    function automatic logic [1:0] polarity(input logic [1:0] code, input logic flip);
        polarity = flip ? ~code : code;
    endfunction : polarity

    function automatic logic [3:0] tolerance_of(input logic [1:0] code);
        unique case (code)
            2'h0: tolerance_of = modem_cfg_pkg::TOL_CODE0;
            2'h1: tolerance_of = modem_cfg_pkg::TOL_CODE1;
            2'h2: tolerance_of = modem_cfg_pkg::TOL_CODE2;
            2'h3: tolerance_of = modem_cfg_pkg::TOL_CODE3;
        endcase
    endfunction : tolerance_of

    ////////////////////////////////////////////////////////////////////////
    // Loop step per bandwidth; hold and tx and powersave stop feedback
    always_comb begin
        unique case (r_reg.loop_bw)
            modem_cfg_pkg::BW_NARROW: step = modem_cfg_pkg::STEP_NARROW;
            modem_cfg_pkg::BW_MEDIUM: step = modem_cfg_pkg::STEP_MEDIUM;
            modem_cfg_pkg::BW_WIDE: step = modem_cfg_pkg::STEP_WIDE;
            modem_cfg_pkg::BW_HOLD: step = '0;
        endcase
    end
    assign fb_en = (r_reg.loop_bw != modem_cfg_pkg::BW_HOLD) && r_reg.analog_en;

    symbol_clock_divider #(
        .CNT_W(modem_cfg_pkg::DIV_W)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .div_sel(r_reg.ctrl.symbol_clock_divider_sel),
        .feedback_en(fb_en),
        .step(step),
        .phase_early(phase_early),
        .phase_late(phase_late),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        logic rx_mode;
        logic access;
        logic mapped;
        logic dir_chg;
        logic pwr_chg;
        logic [modem_cfg_pkg::MISMATCH_W-1:0] sum;
        rx_mode = !r_reg.mode.direction_select;
        access = psel && penable && r_reg.pready;
        mapped = (paddr == modem_cfg_pkg::ADDR_RATE_CTRL) ||
                 (paddr == modem_cfg_pkg::ADDR_OP_MODE) ||
                 (paddr == modem_cfg_pkg::ADDR_STATUS);
        dir_chg = 1'b0;
        pwr_chg = 1'b0;
        sum = r_reg.mismatch;
        r_next = r_reg;
        r_next.task_cancel = 1'b0;
        r_next.buffer_free_flag_set = 1'b0;
        r_next.sync_found = 1'b0;

        // APB: answer is ready in the first access cycle
        r_next.pready = psel && !penable;
        r_next.pslverr = psel && !penable && !mapped;
        r_next.prdata = '0;
        if (psel && !penable && paddr == modem_cfg_pkg::ADDR_STATUS) begin
            r_next.prdata[modem_cfg_pkg::ST_DIR] = r_reg.mode.direction_select;
            r_next.prdata[modem_cfg_pkg::ST_LOWPWR] = r_reg.mode.low_power_select;
            r_next.prdata[modem_cfg_pkg::ST_VALID] = r_reg.out_valid;
            r_next.prdata[modem_cfg_pkg::ST_LVL_ACQ] = r_reg.acq == modem_cfg_pkg::ACQ_SLOW_PEAK;
            r_next.prdata[modem_cfg_pkg::ST_SYNC] = r_reg.sync_found;
        end
        if (access && pwrite && paddr == modem_cfg_pkg::ADDR_RATE_CTRL) begin
            r_next.ctrl_wr = pwdata[modem_cfg_pkg::REG_W-1:0];
        end
        if (access && pwrite && paddr == modem_cfg_pkg::ADDR_OP_MODE) begin
            r_next.mode_wr = pwdata[modem_cfg_pkg::REG_W-1:0];
        end

        // Whole registers move into use on a symbol strobe
        if (tick) begin
            r_next.ctrl = r_reg.ctrl_wr;
            r_next.mode = r_reg.mode_wr;
            dir_chg = r_reg.mode_wr.direction_select != r_reg.mode.direction_select;
            pwr_chg = r_reg.mode_wr.low_power_select != r_reg.mode.low_power_select;
        end
        r_next.task_cancel = dir_chg;
        r_next.buffer_free_flag_set = dir_chg || pwr_chg;

        // Frame sync mismatch total over one comparison
        if (rx_symbol_valid && rx_mode) begin
            if (sync_search_start) begin
                sum = '0;
            end
            sum = sum + modem_cfg_pkg::MISMATCH_W'(level_distance(
                polarity(rx_baseband_in, !r_reg.mode.symbol_polarity_invert),
                sync_expected));
            r_next.mismatch = sum;
            r_next.sync_found = sync_search_end &&
                (sum <= modem_cfg_pkg::MISMATCH_W'(tolerance_of(
                    r_reg.ctrl.sync_mismatch_tolerance)));
        end

        // Level acquisition holds slow peak until sync is found or direction changes
        unique case (r_reg.acq)
            modem_cfg_pkg::ACQ_IDLE: begin
                if (level_acquire_sequence && rx_mode) begin
                    r_next.acq = modem_cfg_pkg::ACQ_SLOW_PEAK;
                end
            end
            modem_cfg_pkg::ACQ_SLOW_PEAK: begin
                if (r_reg.sync_found || dir_chg) begin
                    r_next.acq = modem_cfg_pkg::ACQ_IDLE;
                end
            end
        endcase

        // Effective level mode; transmit leaves the circuits idle
        if (!rx_mode) begin
            r_next.level_mode = modem_cfg_pkg::LVL_HOLD;
        end else if (r_reg.acq == modem_cfg_pkg::ACQ_SLOW_PEAK) begin
            r_next.level_mode = modem_cfg_pkg::LVL_SLOW;
        end else begin
            r_next.level_mode = r_reg.ctrl.level_measure_mode;
        end
        r_next.cap_connect = r_next.level_mode != modem_cfg_pkg::LVL_HOLD;
        r_next.fast_discharge = r_next.level_mode == modem_cfg_pkg::LVL_LOSSY;

        // Loop bandwidth; transmit holds the loop, clock acquisition in receive forces the widest loop
        if (!rx_mode) begin
            r_next.loop_bw = modem_cfg_pkg::BW_HOLD;
        end else if (symbol_clock_acquire_sequence) begin
            r_next.loop_bw = modem_cfg_pkg::BW_WIDE;
        end else begin
            r_next.loop_bw = r_reg.ctrl.clock_loop_bandwidth;
        end

        // Polarity of transmitted and received levels
        r_next.tx_out = polarity(tx_symbol_in, r_reg.mode.symbol_polarity_invert);
        r_next.rx_level = polarity(rx_baseband_in, !r_reg.mode.symbol_polarity_invert);

        // Interrupt pin follows the flag only when enabled
        r_next.irq_n = !(r_reg.mode.interrupt_pin_enable && status_irq_flag);

        // Powersave and the eye test route
        r_next.analog_en = !r_reg.mode.low_power_select;
        r_next.weak_bias = r_reg.mode.low_power_select;
        r_next.eye_route = r_reg.mode.receive_eye_test && rx_mode &&
                           !r_reg.mode.low_power_select;

        // Filters need settle time after power returns
        if (r_reg.mode.low_power_select) begin
            r_next.settle = '0;
            r_next.out_valid = 1'b0;
        end else if (tick && !r_reg.out_valid) begin
            r_next.settle = r_reg.settle + 1'b1;
            r_next.out_valid = r_reg.settle == 8'(SETTLE_COUNT - 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; outputs valid after reset without power cycle delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.ctrl_wr <= modem_cfg_pkg::RATE_CTRL_RESET;
            r_reg.mode_wr <= modem_cfg_pkg::OP_MODE_RESET;
            r_reg.ctrl <= modem_cfg_pkg::RATE_CTRL_RESET;
            r_reg.mode <= modem_cfg_pkg::OP_MODE_RESET;
            r_reg.acq <= modem_cfg_pkg::ACQ_IDLE;
            r_reg.irq_n <= 1'b1;
            r_reg.analog_en <= 1'b1;
            r_reg.out_valid <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign symbol_tick = tick;
    assign tx_baseband_out = r_reg.tx_out;
    assign rx_symbol_level = r_reg.rx_level;
    assign sync_found = r_reg.sync_found;
    assign level_mode_out = r_reg.level_mode;
    assign offset_cap_connect = r_reg.cap_connect;
    assign peak_fast_discharge = r_reg.fast_discharge;
    assign loop_bw_out = r_reg.loop_bw;
    assign interrupt_out_n = r_reg.irq_n;
    assign task_cancel = r_reg.task_cancel;
    assign buffer_free_set = r_reg.buffer_free_flag_set;
    assign eye_route = r_reg.eye_route;
    assign analog_enable = r_reg.analog_en;
    assign tx_weak_bias = r_reg.weak_bias;
    assign output_valid = r_reg.out_valid;

    ////////////////////////////////////////////////////////////////////////
    // Checks beside the logic
    ctrl_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> r_reg.ctrl == $past(r_reg.ctrl_wr))
        else $error("control fields not applied at symbol strobe");
    dir_cancel_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(r_reg.mode.direction_select) |-> task_cancel && buffer_free_set)
        else $error("direction change did not cancel task");
    pwr_free_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(r_reg.mode.low_power_select) |-> buffer_free_set)
        else $error("powersave change did not free buffer");
    irq_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.mode.interrupt_pin_enable && status_irq_flag |=> !interrupt_out_n)
        else $error("interrupt pin not driven low");
    hold_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        level_mode_out == modem_cfg_pkg::LVL_HOLD |-> !offset_cap_connect)
        else $error("offset capacitors connected in hold");
    acq_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.acq == modem_cfg_pkg::ACQ_SLOW_PEAK && !r_reg.mode.direction_select
        |=> level_mode_out == modem_cfg_pkg::LVL_SLOW)
        else $error("acquisition did not force slow peak");
    tx_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.mode.direction_select |=> level_mode_out == modem_cfg_pkg::LVL_HOLD)
        else $error("level mode active in transmit");
    powersave_a: assert property (@(posedge pclk) disable iff (!presetn)
        r_reg.mode.low_power_select |=> !analog_enable && tx_weak_bias && !eye_route)
        else $error("powersave did not disable circuits");
    settle_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(r_reg.mode.low_power_select) |-> !output_valid [*2])
        else $error("output valid too soon after powersave");
    eye_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
        eye_route |-> $past(r_reg.mode.receive_eye_test) && !$past(r_reg.mode.direction_select))
        else $error("eye route outside receive test");
endmodule : modem_mode_regs
`default_nettype wire

/* design/symbol_clock_divider.sv */
// Purpose: Nominal symbol clock from the crystal clock, with loop nudges
// Assumes: Phase pulses are synchronous to the clock
// Notes: Nudges only lengthen or shorten the period being loaded
`timescale 1ns/1ns
`default_nettype none
module symbol_clock_divider #(
    parameter int CNT_W = modem_cfg_pkg::DIV_W
) (
    input wire logic pclk, // Crystal rate clock
    input wire logic presetn, // Async reset, active low
    input wire logic [1:0] div_sel, // Division code
    input wire logic feedback_en, // Loop feedback allowed
    input wire logic [CNT_W-1:0] step, // Nudge size
    input wire logic phase_early, // Local clock early
    input wire logic phase_late, // Local clock late
    output logic tick // One-cycle symbol strobe
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic tick;
    } div_state_t;

    div_state_t r_reg, r_next;

    if (CNT_W < modem_cfg_pkg::DIV_W) begin : g_chk
        $error("symbol_clock_divider: CNT_W too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // Count down, reload with the nominal period, adjusted by the loop
    always_comb begin
        logic [CNT_W-1:0] period;
        period = CNT_W'(modem_cfg_pkg::DIV_BASE << div_sel);
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (r_reg.count == '0) begin
            r_next.tick = 1'b1;
            r_next.count = period - 1'b1;
            // Hold bandwidth leaves the period purely crystal based
            if (feedback_en && phase_late) begin
                r_next.count = period - 1'b1 - step;
            end else if (feedback_en && phase_early) begin
                r_next.count = period - 1'b1 + step;
            end
        end else begin
            r_next.count = r_reg.count - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick = r_reg.tick;
endmodule : symbol_clock_divider
`default_nettype wire

/* tb/apb_host.sv */
// Purpose: Host model issuing APB transfers
// Assumes: xfer is entered just after a rising edge
// Notes: Request held until pready is seen high
`timescale 1ns/1ns
`default_nettype none
module apb_host (
    input wire logic pclk, // Clock
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [31:0] prdata, // Read data
    output logic psel = 1'b0, // Select
    output logic penable = 1'b0, // Access
    output logic pwrite = 1'b0, // Write
    output logic [7:0] paddr = 8'h00, // Address
    output logic [31:0] pwdata = 32'h00000000 // Data
);
    ////////////////////////////////////////////////////////////
    // Bounded wait, so a dead slave cannot hang the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic ok, output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        ok = 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            ok = pready === 1'b1;
            rd = prdata;
            err = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Random and corner checks of the modem mode registers
// Assumes: SETTLE_COUNT shortened to 2
// Notes: Settings are checked after the next symbol strobe
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [7:0] RC = modem_cfg_pkg::ADDR_RATE_CTRL;
    localparam logic [7:0] OM = modem_cfg_pkg::ADDR_OP_MODE;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, status_irq_flag;
    logic rx_symbol_valid, sync_search_start, sync_search_end, phase_early, phase_late;
    logic symbol_clock_acquire_sequence, symbol_tick, sync_found, interrupt_out_n;
    logic task_cancel, buffer_free_set, eye_route, analog_enable, tx_weak_bias, output_valid;
    logic [1:0] tx_symbol_in, rx_baseband_in, sync_expected, tx_baseband_out;
    logic [1:0] rx_symbol_level, level_mode_out, loop_bw_out;
    logic level_acquire_sequence, offset_cap_connect, peak_fast_discharge;
    logic [7:0] paddr, m, p;
    logic [31:0] pwdata, prdata;
    int n_fail, checks_done, seed, n, d, s0, n_can, n_bf, n_sync, e_can, e_bf;
    modem_mode_regs #(.SETTLE_COUNT(2)) dut_u (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .status_irq_flag, .tx_symbol_in,
        .rx_baseband_in, .rx_symbol_valid, .sync_expected, .sync_search_start,
        .sync_search_end, .level_acquire_sequence, .symbol_clock_acquire_sequence,
        .phase_early, .phase_late, .symbol_tick, .tx_baseband_out, .rx_symbol_level,
        .sync_found, .level_mode_out, .offset_cap_connect, .peak_fast_discharge,
        .loop_bw_out, .interrupt_out_n, .task_cancel, .buffer_free_set, .eye_route,
        .analog_enable, .tx_weak_bias, .output_valid);
    apb_host host_u (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
        .paddr, .pwdata);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Pulse tallies, and random loop nudges
    always @(posedge pclk) begin
        n_can <= n_can + (task_cancel === 1'b1);
        n_bf <= n_bf + (buffer_free_set === 1'b1);
        n_sync <= n_sync + (sync_found === 1'b1);
        {phase_early, phase_late} <= 2'($random(seed));
    end
    ////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for k strobes; n ends as the last period
    task automatic ticks(input int k);
        repeat (k) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (symbol_tick !== 1'b1 && n < 9000);
            if (n >= 9000) begin
                n_fail++;
                test_done();
            end
        end
    endtask : ticks
    task automatic settle;
        ticks(1);
        repeat (3) @(posedge pclk);
    endtask : settle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        logic ok, err;
        logic [31:0] rd;
        @(posedge pclk);
        host_u.xfer(w, a, {24'h0, v}, ok, rd, err);
        if (!ok) begin
            n_fail++;
            test_done();
        end
        if (!w) chk({rd, 7'h0, err}, {32'h0, 7'h0, a == 8'h0C});
    endtask : bus
    ////////////////////////////////////////////////////////////
    initial begin
        seed = 71969;
        {n_fail, checks_done, n_can, n_bf, n_sync} = '0;
        {presetn, status_irq_flag, rx_symbol_valid, sync_search_start, sync_search_end} = '0;
        {level_acquire_sequence, symbol_clock_acquire_sequence} = '0;
        {tx_symbol_in, rx_baseband_in, sync_expected} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({interrupt_out_n, analog_enable, output_valid}, 3'h7);
        bus(1'b1, OM, 8'($random(seed)) & 8'hF8);
        bus(1'b0, OM, 8'h00);
        bus(1'b0, RC, 8'h00);
        bus(1'b0, 8'h0C, 8'h00);
        bus(1'b1, OM, 8'h00);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, RC, {i[1:0], 6'h00});
            ticks(3);
            chk(n, 512 << i);
        end
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, RC, {4'h2, i[3:0]});
            settle();
            chk({level_mode_out, loop_bw_out}, i[3:0]);
            m = {6'h00, i[3:2] != 2'h0, i[3:2] == 2'h2};
            chk({offset_cap_connect, peak_fast_discharge}, m[1:0]);
        end
        bus(1'b1, RC, 8'h25);
        symbol_clock_acquire_sequence <= 1'b1;
        settle();
        chk(loop_bw_out, modem_cfg_pkg::BW_WIDE);
        symbol_clock_acquire_sequence <= 1'b0;
        bus(1'b1, OM, 8'h20);
        settle();
        chk({level_mode_out, loop_bw_out}, 4'h0);
        // Random interrupt enable, polarity and symbols in receive
        repeat (8) begin
            m = 8'($random(seed)) & 8'hC0;
            {status_irq_flag, tx_symbol_in, rx_baseband_in} <= 5'($random(seed));
            rx_symbol_valid <= 1'b1;
            bus(1'b1, OM, m);
            settle();
            d = {~(m[7] & status_irq_flag), tx_symbol_in ^ {2{m[6]}}, rx_baseband_in ^ {2{~m[6]}}};
            chk({interrupt_out_n, tx_baseband_out, rx_symbol_level}, d[4:0]);
        end
        // Four-symbol sync searches against each tolerance code
        rx_symbol_valid <= 1'b0;
        bus(1'b1, OM, 8'h00);
        for (int t = 0; t < 8; t++) begin
            bus(1'b1, RC, {2'h0, t[2:1], 4'h6});
            settle();
            d = 0;
            s0 = n_sync;
            for (int k = 0; k < 4; k++) begin
                m = 8'($random(seed));
                d += (m[1:0] > m[3:2]) ? m[1:0] - m[3:2] : m[3:2] - m[1:0];
                {sync_expected, rx_baseband_in} <= {m[1:0], ~m[3:2]};
                {rx_symbol_valid, sync_search_start, sync_search_end} <= {1'b1, k == 0, k == 3};
                level_acquire_sequence <= k == 0;
                @(posedge pclk);
            end
            {rx_symbol_valid, sync_search_end} <= 2'b00;
            repeat (4) @(posedge pclk);
            chk(n_sync - s0, d <= 2 * t[2:1]);
            // Acquisition keeps slow peak until a sync is accepted
            m[1:0] = (d <= 2 * t[2:1]) ? modem_cfg_pkg::LVL_TRACK : modem_cfg_pkg::LVL_SLOW;
            chk(level_mode_out, m[1:0]);
        end
        // Random direction, eye and powersave changes
        {p, e_can, e_bf} = {8'h00, n_can, n_bf};
        repeat (12) begin
            m = 8'($random(seed)) & 8'h38;
            e_can += m[5] != p[5];
            e_bf += m[5] != p[5] || m[3] != p[3];
            bus(1'b1, OM, m);
            settle();
            d = {m[4] & ~m[5] & ~m[3], ~m[3], m[3]};
            chk({eye_route, analog_enable, tx_weak_bias}, d[2:0]);
            chk({8'(n_can), 8'(n_bf)}, {8'(e_can), 8'(e_bf)});
            p = m;
        end
        bus(1'b1, OM, 8'h08);
        settle();
        bus(1'b1, OM, 8'h00);
        settle();
        chk(output_valid, 1'b0);
        ticks(3);
        repeat (2) @(posedge pclk);
        chk(output_valid, 1'b1);
        test_done();
    end
endmodule : testbench
`default_nettype wire
